/* File: amd_consts.vh */
// constants for the operand addressing-mode decoder of an 8-bit core
// assumes a 16-bit address space and 8-bit opcodes of the usual row/column map
// Function
// - ten addressing modes are decoded and reported
// - indexed no-offset instructions are one byte, opcode only
// - no instruction exceeds three bytes; the extended three-byte form carries a full address
// - direct holds one-byte address, extended holds two-byte address
// - extended jumps reach every memory location
// - an operand location is computed for every mode
// - two instruction bytes join with first byte high, second low
// - inherent instructions are one byte and fetch no operand bytes
// - accumulator, index and argument-free control operations are inherent
// - half carry captures the carry out of bit 3
// - each flag is tested, kept, cleared, set or restored from stack
// - byte-offset and word-offset indexed fetch one or two offset bytes
// - immediate operand is byte after opcode; counter advances by two
// - direct drives high address zero, low from byte after opcode
// - byte-offset indexed adds index and offset; carry feeds high byte
// - bit test and branch copies the tested bit into carry
`ifndef AMD_CONSTS_VH
`define AMD_CONSTS_VH

// ----------------------------------------
// mode codes
// ----------------------------------------
`define AMD_MODE_OPONLY 4'h0
`define AMD_MODE_LIT    4'h1
`define AMD_MODE_DIR    4'h2
`define AMD_MODE_LONG   4'h3
`define AMD_MODE_PCOFF  4'h4
`define AMD_MODE_PTR0   4'h5
`define AMD_MODE_PTRB   4'h6
`define AMD_MODE_PTRW   4'h7
`define AMD_MODE_BITSC  4'h8
`define AMD_MODE_BITTB  4'h9

// ----------------------------------------
// flag actions
// ----------------------------------------
`define AMD_FA_KEEP    3'h0
`define AMD_FA_TEST    3'h1
`define AMD_FA_CLR     3'h2
`define AMD_FA_SET     3'h3
`define AMD_FA_STACK   3'h4

// ----------------------------------------
// flag positions in the condition code byte
// ----------------------------------------
`define AMD_CC_C       0
`define AMD_CC_Z       1
`define AMD_CC_N       2
`define AMD_CC_I       3
`define AMD_CC_H       4
`define AMD_CC_RST     5'h08

// ----------------------------------------
// opcode map rows and fixed values
// ----------------------------------------
`define AMD_ROW_BITTB  4'h0
`define AMD_ROW_BITSC  4'h1
`define AMD_ROW_PCOFF  4'h2
`define AMD_ROW_DIR1   4'h3
`define AMD_ROW_INHA   4'h4
`define AMD_ROW_INHX   4'h5
`define AMD_ROW_PTRBR  4'h6
`define AMD_ROW_PTR0R  4'h7
`define AMD_ROW_CTL8   4'h8
`define AMD_ROW_CTL9   4'h9
`define AMD_ROW_LIT    4'hA
`define AMD_ROW_DIR    4'hB
`define AMD_ROW_LONG   4'hC
`define AMD_ROW_PTRW   4'hD
`define AMD_ROW_PTRB   4'hE
`define AMD_ROW_PTR0   4'hF
`define AMD_OP_BSR     8'hAD
`define AMD_OP_RTI     8'h80
`define AMD_OP_SEC     8'h99
`define AMD_OP_CLC     8'h98
`define AMD_OP_SEI     8'h9B
`define AMD_OP_CLI     8'h9A
`define AMD_OP_SWI     8'h83
`define AMD_OP_STOP    8'h8E
`define AMD_OP_WAIT    8'h8F
`define AMD_OP_MUL     8'h42
`define AMD_COL_JMP    4'hC
`define AMD_COL_JSR    4'hD
`define AMD_COL_CPX    4'h3
`define AMD_COL_ADC    4'h9
`define AMD_COL_ADD    4'hB
`define AMD_COL_SBC    4'h2
`define AMD_COL_SUB    4'h0
`define AMD_COL_CMP    4'h1
`define AMD_LEN1       2'h1
`define AMD_LEN2       2'h2
`define AMD_LEN3       2'h3
`define AMD_HI_ZERO    8'h00
`define AMD_PAD7       7'h00
`define AMD_STEP1      16'h0001
`define AMD_STEP2      16'h0002
`define AMD_STEP3      16'h0003
`define AMD_LOC_RST    16'h0000

`endif

/* File: amd_flag_unit.v */
// per-flag action applier for the condition code byte
// assumes result, carries and stacked byte are valid in the update cycle
module amd_flag_unit (
  input  wire       clk_in,
  input  wire       resetn_in,
  input  wire       upd_in,
  input  wire [2:0] act_h_in,
  input  wire [2:0] act_i_in,
  input  wire [2:0] act_n_in,
  input  wire [2:0] act_z_in,
  input  wire [2:0] act_c_in,
  input  wire [7:0] res_in,
  input  wire       c4_in,
  input  wire       c8_in,
  input  wire [7:0] stack_cc_in,
  output reg  [4:0] cc_out
);
  `include "amd_consts.vh"

  // ----------------------------------------
  // one flag's next value from its action
  // ----------------------------------------
  function apply;
    input [2:0] act;
    input       cur;
    input       cond;
    input       stk;
    begin
      case (act)
        `AMD_FA_TEST:  apply = cond;
        `AMD_FA_CLR:   apply = 1'b0;
        `AMD_FA_SET:   apply = 1'b1;
        `AMD_FA_STACK: apply = stk;
        default:       apply = cur;
      endcase
    end
  endfunction

  // ----------------------------------------
  // condition code register update
  // ----------------------------------------
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cc_out <= `AMD_CC_RST;
    end else if (upd_in) begin
      cc_out[`AMD_CC_H] <= apply(act_h_in, cc_out[`AMD_CC_H], c4_in,
                                 stack_cc_in[`AMD_CC_H]);
      cc_out[`AMD_CC_I] <= apply(act_i_in, cc_out[`AMD_CC_I], 1'b0,
                                 stack_cc_in[`AMD_CC_I]);
      cc_out[`AMD_CC_N] <= apply(act_n_in, cc_out[`AMD_CC_N], res_in[7],
                                 stack_cc_in[`AMD_CC_N]);
      cc_out[`AMD_CC_Z] <= apply(act_z_in, cc_out[`AMD_CC_Z], res_in == 8'h00,
                                 stack_cc_in[`AMD_CC_Z]);
      cc_out[`AMD_CC_C] <= apply(act_c_in, cc_out[`AMD_CC_C], c8_in,
                                 stack_cc_in[`AMD_CC_C]);
    end
  end
endmodule

/* File: amd_mem_model.sv */
// program and data memory seen by the decoder
// assumes the bench seeds the generator before calling fill
module amd_mem_model (
  // fetch address
  input  wire logic [15:0] pc_in,
  // opcode, following bytes and the direct byte they name
  output logic      [7:0]  op_out,
  output logic      [7:0]  b1_out,
  output logic      [7:0]  b2_out,
  output logic      [7:0]  dir_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:65535];
  // combinational reads; a whole instruction is visible at once
  assign op_out  = mem[pc_in];
  assign b1_out  = mem[pc_in + 16'h0001];
  assign b2_out  = mem[pc_in + 16'h0002];
  assign dir_out = mem[{8'h00, b1_out}];
  // random contents give random opcodes and operands
  task automatic fill();
    for (int a = 0; a < 65536; a++) mem[a] = 8'($urandom);
  endtask
endmodule

/* File: amd_mode_decode.v */
// addressing-mode decoder: mode, length, operand location, next counter, flags
// assumes opcode and the two following bytes are presented together, one
// instruction per cycle when OP_VALID_IN is high
module amd_mode_decode (
  // clock and reset
  input  wire        CLK_SYS_IN,
  input  wire        RESETN_IN,
  // instruction bytes and core state
  input  wire        OP_VALID_IN,
  input  wire [7:0]  OPCODE_IN,
  input  wire [7:0]  BYTE1_IN,
  input  wire [7:0]  BYTE2_IN,
  input  wire [15:0] PC_IN,
  input  wire [7:0]  INDEX_IN,
  // operand and result information
  input  wire [7:0]  MEM_BYTE_IN,
  input  wire        BRANCH_COND_IN,
  input  wire [7:0]  ALU_RES_IN,
  input  wire        ALU_C4_IN,
  input  wire        ALU_C8_IN,
  input  wire [7:0]  STACK_CC_IN,
  // decode results
  output reg  [3:0]  MODE_OUT,
  output reg  [1:0]  LENGTH_OUT,
  output reg  [15:0] OPERAND_LOCATION_OUT,
  output reg  [15:0] NEXT_PC_OUT,
  output reg         DECODE_VALID_OUT,
  output wire [4:0]  CC_OUT
);
  `include "amd_consts.vh"

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // first byte high, second low
  function [15:0] join16;
    input [7:0] hi;
    input [7:0] lo;
    begin
      join16 = {hi, lo};
    end
  endfunction

  // signed 8-bit branch offset added to a base
  function [15:0] rel_add;
    input [15:0] base;
    input [7:0]  off;
    begin
      rel_add = base + {{8{off[7]}}, off};
    end
  endfunction

  // ----------------------------------------
  // mode and length decode
  // ----------------------------------------
  wire [3:0] row = OPCODE_IN[7:4];
  wire [3:0] col = OPCODE_IN[3:0];
  reg  [3:0] mode_nxt;
  reg  [1:0] len_nxt;

  // the upper nibble alone picks the mode, with one exception: the
  // subroutine branch sits in the literal row but is counter-relative
  always @* begin
    mode_nxt = `AMD_MODE_OPONLY;
    case (row)
      // bit manipulation rows, both naming a byte in the lowest page
      `AMD_ROW_BITTB: mode_nxt = `AMD_MODE_BITTB;
      `AMD_ROW_BITSC: mode_nxt = `AMD_MODE_BITSC;
      // conditional branches
      `AMD_ROW_PCOFF: mode_nxt = `AMD_MODE_PCOFF;
      // read/modify/write and control forms
      `AMD_ROW_DIR1:  mode_nxt = `AMD_MODE_DIR;
      `AMD_ROW_INHA,
      `AMD_ROW_INHX,
      `AMD_ROW_CTL8,
      `AMD_ROW_CTL9:  mode_nxt = `AMD_MODE_OPONLY;
      `AMD_ROW_PTRBR: mode_nxt = `AMD_MODE_PTRB;
      `AMD_ROW_PTR0R: mode_nxt = `AMD_MODE_PTR0;
      // register/memory forms
      `AMD_ROW_LIT: begin
        if (OPCODE_IN == `AMD_OP_BSR) begin
          mode_nxt = `AMD_MODE_PCOFF;
        end else begin
          mode_nxt = `AMD_MODE_LIT;
        end
      end
      `AMD_ROW_DIR:   mode_nxt = `AMD_MODE_DIR;
      `AMD_ROW_LONG:  mode_nxt = `AMD_MODE_LONG;
      `AMD_ROW_PTRW:  mode_nxt = `AMD_MODE_PTRW;
      `AMD_ROW_PTRB:  mode_nxt = `AMD_MODE_PTRB;
      `AMD_ROW_PTR0:  mode_nxt = `AMD_MODE_PTR0;
      default:        mode_nxt = `AMD_MODE_OPONLY;
    endcase
  end

  // length follows mode; three bytes at most, so a two-bit field suffices
  always @* begin
    case (mode_nxt)
      // opcode alone, no operand fetch
      `AMD_MODE_OPONLY: len_nxt = `AMD_LEN1;
      `AMD_MODE_PTR0:   len_nxt = `AMD_LEN1;
      // one or two offset bytes follow the opcode
      `AMD_MODE_PTRB:   len_nxt = `AMD_LEN2;
      `AMD_MODE_PTRW:   len_nxt = `AMD_LEN3;
      // the three-byte forms
      `AMD_MODE_LONG:   len_nxt = `AMD_LEN3;
      `AMD_MODE_BITTB:  len_nxt = `AMD_LEN3;
      default:          len_nxt = `AMD_LEN2;
    endcase
  end

  // ----------------------------------------
  // operand location and next counter
  // ----------------------------------------
  // byte-offset sum keeps its carry as a ninth bit
  wire [8:0]  ptrb_sum = {1'b0, INDEX_IN} + {1'b0, BYTE1_IN};
  // word-offset sum may carry into the high byte
  wire [15:0] ptrw_sum = join16(BYTE1_IN, BYTE2_IN) + join16(`AMD_HI_ZERO, INDEX_IN);
  // counter stepped past one, two and three instruction bytes
  wire [15:0] pc1      = PC_IN + `AMD_STEP1;
  wire [15:0] pc2      = PC_IN + `AMD_STEP2;
  wire [15:0] pc3      = PC_IN + `AMD_STEP3;
  // jump and subroutine-jump columns
  wire        is_jump  = (col == `AMD_COL_JMP) || (col == `AMD_COL_JSR);
  // bit number comes from opcode bits 3..1
  wire        bit_val  = MEM_BYTE_IN[OPCODE_IN[3:1]];
  // even opcodes branch on set, odd on clear
  wire        bit_take = OPCODE_IN[0] ? ~bit_val : bit_val;
  reg  [15:0] loc_nxt;
  reg  [15:0] pc_nxt;

  // operand location for every mode; opcode-only forms point at
  // themselves so the output never carries a stale address
  always @* begin
    loc_nxt = pc1;
    case (mode_nxt)
      `AMD_MODE_OPONLY: loc_nxt = PC_IN;
      // operand is the byte right after the opcode
      `AMD_MODE_LIT:    loc_nxt = pc1;
      // short absolute forms: high byte forced to zero
      `AMD_MODE_DIR,
      `AMD_MODE_BITSC,
      `AMD_MODE_BITTB:  loc_nxt = join16(`AMD_HI_ZERO, BYTE1_IN);
      // long absolute form: full address from the two bytes
      `AMD_MODE_LONG:   loc_nxt = join16(BYTE1_IN, BYTE2_IN);
      // pointer forms; the byte-offset carry lands in bit 8 only
      `AMD_MODE_PTR0:   loc_nxt = join16(`AMD_HI_ZERO, INDEX_IN);
      `AMD_MODE_PTRB:   loc_nxt = {`AMD_PAD7, ptrb_sum};
      `AMD_MODE_PTRW:   loc_nxt = ptrw_sum;
      // branch target, followed only when the condition holds
      `AMD_MODE_PCOFF:  loc_nxt = rel_add(pc2, BYTE1_IN);
      default:          loc_nxt = pc1;
    endcase
  end

  // next counter: a plain step by length unless a long-form jump or a
  // taken branch redirects it
  always @* begin
    pc_nxt = pc1;
    case (mode_nxt)
      `AMD_MODE_OPONLY,
      `AMD_MODE_PTR0:   pc_nxt = pc1;
      `AMD_MODE_LIT,
      `AMD_MODE_DIR,
      `AMD_MODE_BITSC,
      `AMD_MODE_PTRB:   pc_nxt = pc2;
      `AMD_MODE_PTRW:   pc_nxt = pc3;
      // long jumps reach the whole space
      `AMD_MODE_LONG: begin
        if (row[3] && is_jump) begin
          pc_nxt = loc_nxt;
        end else begin
          pc_nxt = pc3;
        end
      end
      `AMD_MODE_PCOFF: begin
        if (BRANCH_COND_IN) begin
          pc_nxt = loc_nxt;
        end else begin
          pc_nxt = pc2;
        end
      end
      // the tested bit decides; the third byte is the offset
      `AMD_MODE_BITTB: begin
        if (bit_take) begin
          pc_nxt = rel_add(pc3, BYTE2_IN);
        end else begin
          pc_nxt = pc3;
        end
      end
      default:          pc_nxt = pc1;
    endcase
  end

  // ----------------------------------------
  // flag action selection
  // ----------------------------------------
  // only a representative set of opcodes is classified; others keep flags
  reg [2:0] act_h;
  reg [2:0] act_i;
  reg [2:0] act_n;
  reg [2:0] act_z;
  reg [2:0] act_c;
  reg       c_src;
  wire      is_alu = row[3] && (row != `AMD_ROW_CTL8) && (row != `AMD_ROW_CTL9);

  always @* begin
    act_h = `AMD_FA_KEEP;
    act_i = `AMD_FA_KEEP;
    act_n = `AMD_FA_KEEP;
    act_z = `AMD_FA_KEEP;
    act_c = `AMD_FA_KEEP;
    c_src = ALU_C8_IN;
    // tested bit goes to carry whether or not the branch is taken
    if (mode_nxt == `AMD_MODE_BITTB) begin
      act_c = `AMD_FA_TEST;
      c_src = bit_val;
    end else if (OPCODE_IN == `AMD_OP_RTI) begin
      act_h = `AMD_FA_STACK;
      act_i = `AMD_FA_STACK;
      act_n = `AMD_FA_STACK;
      act_z = `AMD_FA_STACK;
      act_c = `AMD_FA_STACK;
    end else if (OPCODE_IN == `AMD_OP_SEC) begin
      act_c = `AMD_FA_SET;
    end else if (OPCODE_IN == `AMD_OP_CLC) begin
      act_c = `AMD_FA_CLR;
    end else if (OPCODE_IN == `AMD_OP_SEI || OPCODE_IN == `AMD_OP_SWI) begin
      act_i = `AMD_FA_SET;
    end else if (OPCODE_IN == `AMD_OP_CLI || OPCODE_IN == `AMD_OP_STOP ||
                 OPCODE_IN == `AMD_OP_WAIT) begin
      act_i = `AMD_FA_CLR;
    end else if (OPCODE_IN == `AMD_OP_MUL) begin
      act_h = `AMD_FA_CLR;
      act_c = `AMD_FA_CLR;
    end else if (is_alu && !is_jump) begin
      act_n = `AMD_FA_TEST;
      act_z = `AMD_FA_TEST;
      if (col == `AMD_COL_ADC || col == `AMD_COL_ADD) begin
        act_h = `AMD_FA_TEST;
        act_c = `AMD_FA_TEST;
      end else if (col == `AMD_COL_SBC || col == `AMD_COL_SUB ||
                   col == `AMD_COL_CMP || col == `AMD_COL_CPX) begin
        act_c = `AMD_FA_TEST;
      end
    end
  end

  amd_flag_unit u_flags (
    .clk_in      (CLK_SYS_IN),
    .resetn_in   (RESETN_IN),
    .upd_in      (OP_VALID_IN),
    .act_h_in    (act_h),
    .act_i_in    (act_i),
    .act_n_in    (act_n),
    .act_z_in    (act_z),
    .act_c_in    (act_c),
    .res_in      (ALU_RES_IN),
    .c4_in       (ALU_C4_IN),
    .c8_in       (c_src),
    .stack_cc_in (STACK_CC_IN),
    .cc_out      (CC_OUT)
  );

  // ----------------------------------------
  // registered decode outputs
  // ----------------------------------------
  // results hold between accepted instructions so a slow consumer can
  // read them late; only the valid flag is a one-cycle pulse
  always @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      MODE_OUT             <= `AMD_MODE_OPONLY;
      LENGTH_OUT           <= `AMD_LEN1;
      OPERAND_LOCATION_OUT <= `AMD_LOC_RST;
      NEXT_PC_OUT          <= `AMD_LOC_RST;
      DECODE_VALID_OUT     <= 1'b0;
    end else begin
      DECODE_VALID_OUT <= OP_VALID_IN;
      if (OP_VALID_IN) begin
        MODE_OUT             <= mode_nxt;
        LENGTH_OUT           <= len_nxt;
        OPERAND_LOCATION_OUT <= loc_nxt;
        NEXT_PC_OUT          <= pc_nxt;
      end
    end
  end
endmodule

/* File: amd_mode_decode_asserts.sv */
// port assertions for the addressing-mode decoder
// assumes one clock domain and the asynchronous active-low reset
module amd_mode_decode_chk (
  // clock and reset
  input wire logic        CLK_SYS_IN,
  input wire logic        RESETN_IN,
  // request side
  input wire logic        OP_VALID_IN,
  input wire logic [7:0]  OPCODE_IN,
  input wire logic [7:0]  BYTE1_IN,
  input wire logic [7:0]  BYTE2_IN,
  input wire logic [15:0] PC_IN,
  input wire logic [7:0]  INDEX_IN,
  input wire logic [7:0]  MEM_BYTE_IN,
  // decode results
  input wire logic [3:0]  MODE_OUT,
  input wire logic [1:0]  LENGTH_OUT,
  input wire logic [15:0] OPERAND_LOCATION_OUT,
  input wire logic [15:0] NEXT_PC_OUT,
  input wire logic        DECODE_VALID_OUT,
  input wire logic [4:0]  CC_OUT
);
  // bit named by the opcode, captured so $past sees a plain signal
  logic tested_bit;
  assign tested_bit = MEM_BYTE_IN[OPCODE_IN[3:1]];
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESETN_IN);
  // ----
  // an accepted instruction from one of two opcode rows
  // ----
  sequence s_take(logic [3:0] ra, logic [3:0] rb);
    OP_VALID_IN && (OPCODE_IN[7:4] == ra || OPCODE_IN[7:4] == rb);
  endsequence
  property p_answer; OP_VALID_IN |-> ##1 DECODE_VALID_OUT; endproperty
  a_answer: assert property (p_answer) else $error("decode result missing");
  // idle cycles drop valid and leave the operand location and flags alone
  property p_idle;
    !OP_VALID_IN |=> !DECODE_VALID_OUT && $stable(OPERAND_LOCATION_OUT) && $stable(CC_OUT);
  endproperty
  a_idle: assert property (p_idle) else $error("outputs moved while idle");
  property p_len; DECODE_VALID_OUT |-> LENGTH_OUT != 2'h0; endproperty
  a_len: assert property (p_len) else $error("length outside one to three");
  property p_inh;
    (s_take(4'h4, 4'h5) or s_take(4'h8, 4'h9)) |=> MODE_OUT == 4'h0 && LENGTH_OUT == 2'h1;
  endproperty
  a_inh: assert property (p_inh) else $error("opcode-only form not one byte");
  property p_ix0;
    s_take(4'h7, 4'hF) |=> LENGTH_OUT == 2'h1 && OPERAND_LOCATION_OUT == {8'h00, $past(INDEX_IN)};
  endproperty
  a_ix0: assert property (p_ix0) else $error("no-offset pointer form wrong");
  property p_ext;
    s_take(4'hC, 4'hC) |=> LENGTH_OUT == 2'h3
      && OPERAND_LOCATION_OUT == {$past(BYTE1_IN), $past(BYTE2_IN)};
  endproperty
  a_ext: assert property (p_ext) else $error("long absolute address wrong");
  property p_dir; s_take(4'h3, 4'hB) |=> OPERAND_LOCATION_OUT == {8'h00, $past(BYTE1_IN)};
  endproperty
  a_dir: assert property (p_dir) else $error("short absolute address wrong");
  property p_imm;
    s_take(4'hA, 4'hA) ##0 OPCODE_IN != 8'hAD |=> NEXT_PC_OUT == $past(PC_IN) + 16'h0002;
  endproperty
  a_imm: assert property (p_imm) else $error("literal form counter wrong");
  property p_ix1;
    s_take(4'h6, 4'hE) |=> OPERAND_LOCATION_OUT == {8'h00, $past(INDEX_IN)} + {8'h00, $past(BYTE1_IN)};
  endproperty
  a_ix1: assert property (p_ix1) else $error("byte-offset sum wrong");
  property p_ix2;
    s_take(4'hD, 4'hD) |=> OPERAND_LOCATION_OUT
      == {$past(BYTE1_IN), $past(BYTE2_IN)} + {8'h00, $past(INDEX_IN)};
  endproperty
  a_ix2: assert property (p_ix2) else $error("word-offset sum wrong");
  property p_jmp; s_take(4'hC, 4'hC) ##0 OPCODE_IN[3:1] == 3'h6 |=> NEXT_PC_OUT == OPERAND_LOCATION_OUT;
  endproperty
  a_jmp: assert property (p_jmp) else $error("long jump misses target");
  property p_btb; s_take(4'h0, 4'h0) |=> CC_OUT[0] == $past(tested_bit);
  endproperty
  a_btb: assert property (p_btb) else $error("tested bit not in carry");
endmodule

bind amd_mode_decode amd_mode_decode_chk i_chk (.CLK_SYS_IN, .RESETN_IN, .OP_VALID_IN,
  .OPCODE_IN, .BYTE1_IN, .BYTE2_IN, .PC_IN, .INDEX_IN, .MEM_BYTE_IN, .MODE_OUT, .LENGTH_OUT,
  .OPERAND_LOCATION_OUT, .NEXT_PC_OUT, .DECODE_VALID_OUT, .CC_OUT);

/* File: cpu_addressing_mode_decode_test.sv */
// self-checking bench for the addressing-mode decoder
// assumes amd_mode_decode, its checker and amd_mem_model are compiled first
module cpu_addressing_mode_decode_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rstn = 0, opv = 0, cond = 0, c4 = 0, c8 = 0, dv;
  logic [7:0] op = 0, b1 = 0, b2 = 0, x = 0, mb = 0, res = 0, stk = 0;
  logic [7:0] m_op, m_b1, m_b2, m_db;
  logic [15:0] pc = 0, loc, npc;
  logic [3:0] mode;
  logic [1:0] len;
  logic [4:0] cc;
  logic [38:0] q[$];
  logic [38:0] e;
  int n_mismatch = 0, n_compared = 0;

  always #2 clk = ~clk;
  amd_mode_decode i_dut (.CLK_SYS_IN(clk), .RESETN_IN(rstn), .OP_VALID_IN(opv),
    .OPCODE_IN(op), .BYTE1_IN(b1), .BYTE2_IN(b2), .PC_IN(pc), .INDEX_IN(x),
    .MEM_BYTE_IN(mb), .BRANCH_COND_IN(cond), .ALU_RES_IN(res), .ALU_C4_IN(c4),
    .ALU_C8_IN(c8), .STACK_CC_IN(stk), .MODE_OUT(mode), .LENGTH_OUT(len),
    .OPERAND_LOCATION_OUT(loc), .NEXT_PC_OUT(npc), .DECODE_VALID_OUT(dv), .CC_OUT(cc));
  amd_mem_model i_mem (.pc_in(pc), .op_out(m_op), .b1_out(m_b1), .b2_out(m_b2), .dir_out(m_db));

  // ----
  // reference: {check counter, mode, length, location, next counter}
  // ----
  function automatic logic [38:0] model(input logic [7:0] o, p1, p2, xr, m,
                                        input logic [15:0] a, input logic cnd);
    logic [3:0] r, md;
    logic [1:0] ln;
    logic [15:0] l, n, pc_offset_branch_mode;
    logic k;
    r = o[7:4];
    // jumps outside the long form and control flow of row 8 are not predicted
    k = !(r > 4'h8 && r != 4'hC && o[3:1] == 3'h6) && r != 4'h8;
    pc_offset_branch_mode = a + 16'h0002 + {{8{p1[7]}}, p1};
    md = 4'h0;
    ln = 2'h1;
    l = a;
    case (r)
      4'h0: begin md = 4'h9; ln = 2'h3; l = {8'h00, p1}; end
      4'h1: begin md = 4'h8; ln = 2'h2; l = {8'h00, p1}; end
      4'h2: begin md = 4'h4; ln = 2'h2; l = pc_offset_branch_mode; end
      4'h3, 4'hB: begin md = 4'h2; ln = 2'h2; l = {8'h00, p1}; end
      4'h6, 4'hE: begin md = 4'h6; ln = 2'h2; l = {8'h00, xr} + {8'h00, p1}; end
      4'h7, 4'hF: begin md = 4'h5; l = {8'h00, xr}; end
      4'hA: begin md = 4'h1; ln = 2'h2; l = a + 16'h0001; end
      4'hC: begin md = 4'h3; ln = 2'h3; l = {p1, p2}; end
      4'hD: begin md = 4'h7; ln = 2'h3; l = {p1, p2} + {8'h00, xr}; end
      default: ;
    endcase
    if (o == 8'hAD) begin md = 4'h4; l = pc_offset_branch_mode; k = 1'b0; end
    n = a + {14'h0, ln};
    if (r == 4'h2 && cnd) n = pc_offset_branch_mode;
    if (r == 4'h0 && (m[o[3:1]] ^ o[0])) n = a + 16'h0003 + {{8{p2[7]}}, p2};
    if (r == 4'hC && o[3:1] == 3'h6) n = l;
    return {k, md, ln, l, n};
  endfunction

  task automatic chk(input logic [38:0] got, input logic [38:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // reset held six cycles; flags come out with only the mask set
  task automatic do_reset();
    @(negedge clk);
    rstn = 0;
    opv = 0;
    q.delete();
    repeat (6) @(negedge clk);
    rstn = 1;
    chk({34'h0, cc}, {34'h0, 5'h08}, "reset flags");
  endtask

  // one instruction for its flag effect, result read one cycle later
  task automatic flag_step(input logic [7:0] o, s, r, m, input logic [1:0] c, input logic [4:0] ex);
    @(negedge clk);
    opv = 1;
    op = o;
    stk = s;
    res = r;
    mb = m;
    {c4, c8} = c;
    @(negedge clk);
    opv = 0;
    chk({34'h0, cc}, {34'h0, ex}, "flags");
  endtask

  // back-to-back random instructions with idle gaps, checked every cycle
  task automatic run_random(input int cnt);
    for (int i = 0; i <= cnt; i++) begin
      @(negedge clk);
      chk({38'h0, dv}, {38'h0, q.size() != 0}, "valid");
      if (q.size() != 0) begin
        e = q.pop_front();
        chk({1'b0, mode, len, loc, e[38] ? npc : e[15:0]}, {1'b0, e[37:0]}, "decode");
      end
      opv = (i < cnt) && ($urandom % 4 != 0);
      pc = 16'($urandom);
      x = 8'($urandom);
      {cond, c4, c8, res, stk} = 19'($urandom);
      #1;
      op = m_op;
      b1 = m_b1;
      b2 = m_b2;
      mb = m_db;
      if (opv) q.push_back(model(op, b1, b2, x, mb, pc, cond));
    end
    $display("random run of %0d slots done", cnt);
  endtask

  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end

  initial begin
    void'($urandom(32'hCF4B));
    i_mem.fill();
    do_reset();
    flag_step(8'h99, 8'h00, 8'h00, 8'h00, 2'h0, 5'h09);
    flag_step(8'h9A, 8'h00, 8'h00, 8'h00, 2'h0, 5'h01);
    flag_step(8'hAB, 8'h00, 8'h80, 8'h00, 2'h2, 5'h14);
    flag_step(8'hAB, 8'h00, 8'h00, 8'h00, 2'h1, 5'h03);
    flag_step(8'h42, 8'h00, 8'h00, 8'h00, 2'h0, 5'h02);
    flag_step(8'h9B, 8'h00, 8'h00, 8'h00, 2'h0, 5'h0A);
    flag_step(8'h80, 8'hF5, 8'h00, 8'h00, 2'h0, 5'h15);
    flag_step(8'h98, 8'h00, 8'h00, 8'h00, 2'h0, 5'h14);
    flag_step(8'h00, 8'h00, 8'h00, 8'h01, 2'h0, 5'h15);
    flag_step(8'h03, 8'h00, 8'h00, 8'hFD, 2'h0, 5'h14);
    $display("flag actions done");
    run_random(1500);
    do_reset();
    run_random(300);
    conclude();
  end
endmodule
